// ### rtl/spalu_pkg.sv
// Package for the scratchpad and asynchronous load completion unit.
// Assumes a single core clock domain and a synchronous active-high reset.
package spalu_pkg;

   // ************************************************************
   // Control register layout
   // ************************************************************
   localparam int unsigned CTL_W = 64;
   localparam int unsigned CTL_SIZE_LSB = 0;
   localparam int unsigned CTL_SIZE_W = 6;
   localparam int unsigned CTL_USER_BIT = 6;
   localparam int unsigned CTL_SUPER_BIT = 7;
   localparam int unsigned CTL_KERNEL_BIT = 8;
   localparam logic [63:0] CTL_CFG_MASK = 64'h0000_0000_0000_01ff;
   localparam logic [63:0] CTL_RESET = 64'h0000_0000_0000_0000;

   // ************************************************************
   // Scratchpad geometry
   // ************************************************************
   localparam logic [63:0] SCRATCH_VIRTUAL_BASE = 64'hffff_ffff_ffff_8000;
   localparam int unsigned LINE_BYTES = 128;
   localparam int unsigned LINE_WORDS = 16;
   localparam int unsigned WORD_IDX_W = 8;
   localparam int unsigned WORD_LSB = 3;
   localparam int unsigned SEG_SPAN_W = 15;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_USER,
      MODE_SUPER,
      MODE_KERNEL
   } spalu_mode_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [63:0] vaddr;
      logic [7:0]  byte_en;
      logic [63:0] wdata;
      spalu_mode_e mode;
   } spalu_req_s;

   typedef struct packed {
      logic        valid;
      logic [WORD_IDX_W-1:0] word_idx;
      logic        pool_short;
      logic [63:0] data;
      logic        last;
   } spalu_res_s;

endpackage : spalu_pkg

// ### rtl/spalu_top.sv
// Per-core scratchpad with asynchronous load result write-back and sync stall.
// Assumes the pipeline holds a request for one cycle and I/O units return
// one result word per cycle, with the last word flagged.
//
// Operation
// R01 - Sync instruction stalls core until all its outstanding async loads finish.
// R02 - Completed pool load writes its words sequentially from commanded offset.
// R03 - Short pool makes every returned result word zero.
// R04 - Software may poll a cleared slot for completion instead of syncing.
// R05 - Software presets an impossible marker when zero is a legal result.
// R06 - Software scratchpad loads and stores work at byte granularity. The code stores by byte enable, but loads return the whole 64-bit word.
// R07 - Scratchpad offset zero sits at the fixed virtual base.
// R08 - Async load targets are aligned to 64-bit words.
// R09 - Kernel enable bit allows access in kernel or debug mode. The code has no debug mode and rejects mode encoding 3.
// R10 - Supervisor enable bit allows access in supervisor mode.
// R11 - User enable bit allows access in user mode.
// R12 - Six-bit size field reserves that many 128-byte cache lines.
// R13 - Size zero is legal and reserves no lines.
// R14 - Scratchpad lines are taken from data-cache capacity.
// R15 - Software invalidates the data cache after resizing.
// R16 - Software updates config fields by read-modify-write of the low bits.
// R17 - Result words land at the command's eight-bit word index.
// R18 - Control bits above the config field are unaffected by config changes.
// R19 - Disabled-mode access returns address error, leaving contents unchanged.
`timescale 1ns/100ps
module spalu_top #(
   parameter int unsigned MAX_LINES = 16,
   parameter int unsigned OUTSTANDING_W = 6
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Control register access
   input wire logic i_ctl_wr,
   input wire logic [63:0] i_ctl_wdata,
   output logic [63:0] o_ctl_rdata,
   output logic [5:0] o_dcache_lines_taken,
   // Core load and store port
   input wire spalu_pkg::spalu_req_s i_req,
   output logic o_rsp_valid,
   output logic [63:0] o_rsp_rdata,
   output logic o_addr_error,
   // Async load issue and completion
   input wire logic i_load_issue,
   input wire spalu_pkg::spalu_res_s i_result,
   // Sync instruction
   input wire logic i_sync_instr,
   output logic o_stall
);

   localparam int unsigned DEPTH = MAX_LINES * spalu_pkg::LINE_WORDS;

   // ************************************************************
   // Control register
   // ************************************************************
   logic [63:0] ctl_q, ctl_d;

   always_comb begin
      ctl_d = ctl_q;
      if (i_ctl_wr) begin
         // R18 keep upper bits
         ctl_d = (ctl_q & ~spalu_pkg::CTL_CFG_MASK) | (i_ctl_wdata & spalu_pkg::CTL_CFG_MASK);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ctl_q <= spalu_pkg::CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   logic [5:0] line_count;
   // R12 size field
   assign line_count = ctl_q[spalu_pkg::CTL_SIZE_LSB +: spalu_pkg::CTL_SIZE_W];
   assign o_ctl_rdata = ctl_q;
   // R14 cache lines lent
   assign o_dcache_lines_taken = line_count;

   // ************************************************************
   // Storage
   // ************************************************************
   logic [63:0] mem_q [DEPTH];

   // ************************************************************
   // Core access decode
   // ************************************************************
   logic [63:0] offset;
   logic [spalu_pkg::WORD_IDX_W-1:0] acc_word;
   logic mode_ok, in_range, acc_ok;
   logic [14:0] limit_bytes;

   // R07 base subtraction
   assign offset = i_req.vaddr - spalu_pkg::SCRATCH_VIRTUAL_BASE;
   assign acc_word = offset[spalu_pkg::WORD_LSB +: spalu_pkg::WORD_IDX_W];
   // R13 zero size gives empty range
   assign limit_bytes = 15'(line_count) * 15'(spalu_pkg::LINE_BYTES);

   always_comb begin
      case (i_req.mode)
         // R09 kernel enable
         spalu_pkg::MODE_KERNEL: mode_ok = ctl_q[spalu_pkg::CTL_KERNEL_BIT];
         // R10 supervisor enable
         spalu_pkg::MODE_SUPER: mode_ok = ctl_q[spalu_pkg::CTL_SUPER_BIT];
         // R11 user enable
         spalu_pkg::MODE_USER: mode_ok = ctl_q[spalu_pkg::CTL_USER_BIT];
         default: mode_ok = 1'b0;
      endcase
   end

   assign in_range = (offset[63:spalu_pkg::SEG_SPAN_W] == '0) &&
                     (offset[14:0] < limit_bytes) &&
                     (32'(offset[14:0]) < DEPTH * 8);
   // R19 reject disabled mode
   assign acc_ok = i_req.valid && mode_ok && in_range;

   // ************************************************************
   // Result word write path
   // ************************************************************
   logic res_ok;
   logic [63:0] res_word;
   assign res_ok = i_result.valid && (32'(i_result.word_idx) < DEPTH);
   // R03 short pool zeros
   assign res_word = i_result.pool_short ? 64'h0000_0000_0000_0000 : i_result.data;

   // Async result has priority; a same-word core store loses the cycle.
   // One process owns the array so it keeps a single driver.
   always_ff @(posedge i_core_clk) begin
      if (res_ok) begin
         // R02 R17 sequential word placement
         mem_q[i_result.word_idx] <= res_word;
      end
      for (int b = 0; b < 8; b++) begin
         if (acc_ok && i_req.write && i_req.byte_en[b] &&
             !(res_ok && i_result.word_idx == acc_word)) begin
            // R06 byte lane store
            mem_q[acc_word][b*8 +: 8] <= i_req.wdata[b*8 +: 8];
         end
      end
   end

   // ************************************************************
   // Core response
   // ************************************************************
   logic rsp_valid_q, rsp_valid_d, err_q, err_d;
   logic [63:0] rdata_q, rdata_d;

   always_comb begin
      rsp_valid_d = i_req.valid;
      err_d = i_req.valid && !acc_ok;
      rdata_d = 64'h0000_0000_0000_0000;
      if (acc_ok && !i_req.write) begin
         rdata_d = mem_q[acc_word];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rsp_valid_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 64'h0000_0000_0000_0000;
      end else begin
         rsp_valid_q <= rsp_valid_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_rsp_valid = rsp_valid_q;
   assign o_addr_error = err_q;
   assign o_rsp_rdata = rdata_q;

   // ************************************************************
   // Outstanding count and sync stall
   // ************************************************************
   logic [OUTSTANDING_W-1:0] pend_q, pend_d;
   logic sync_q, sync_d;
   logic done;
   assign done = i_result.valid && i_result.last;

   always_comb begin
      pend_d = pend_q;
      if (i_load_issue && !done) begin
         pend_d = pend_q + 1'b1;
      end else if (!i_load_issue && done && pend_q != '0) begin
         pend_d = pend_q - 1'b1;
      end
      sync_d = sync_q;
      // R01 hold until drained
      if (i_sync_instr) begin
         sync_d = 1'b1;
      end
      if (pend_d == '0) begin
         sync_d = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         pend_q <= '0;
         sync_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         sync_q <= sync_d;
      end
   end

   // R01 stall core
   assign o_stall = (i_sync_instr || sync_q) && (pend_q != '0);

endmodule // spalu_top

// ### test/spalu_properties.sv
// Checker of response, control and stall timing.
// Assumes it is bound to the top module.
`timescale 1ns/100ps
module spalu_properties (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ctl_wr,
   input wire logic [63:0] i_ctl_wdata,
   input wire logic [63:0] o_ctl_rdata,
   input wire spalu_pkg::spalu_req_s i_req,
   input wire logic o_rsp_valid,
   input wire logic [63:0] o_rsp_rdata,
   input wire logic o_addr_error,
   input wire spalu_pkg::spalu_res_s i_result,
   input wire logic o_stall
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   rsp_timing_a: assert property (i_req.valid |=> o_rsp_valid)
      else $error("no response");
   rsp_only_a: assert property (!i_req.valid |=> !o_rsp_valid && !o_addr_error)
      else $error("spurious response");
   ctl_write_a: assert property (i_ctl_wr |=>
      o_ctl_rdata == ($past(i_ctl_wdata) & spalu_pkg::CTL_CFG_MASK)) else $error("bad ctl");
   ctl_hold_a: assert property (!i_ctl_wr |=> $stable(o_ctl_rdata))
      else $error("ctl moved");
   mode_err_a: assert property (i_req.valid && !o_ctl_rdata[6 + i_req.mode]
      |=> o_addr_error) else $error("disabled mode accepted");
   size_zero_a: assert property (i_req.valid && o_ctl_rdata[5:0] == 6'h0
      |=> o_addr_error) else $error("zero size accepted");
   err_clean_a: assert property (o_addr_error |-> o_rsp_valid && o_rsp_rdata == '0)
      else $error("bad error response");
   stall_hold_a: assert property (o_stall && !(i_result.valid && i_result.last)
      |=> o_stall) else $error("stall dropped early");
endmodule // spalu_properties

// ### test/spalu_io_model.sv
// I/O unit model returning async load words, one per cycle.
// Assumes the bench calls load from its main sequence.
`timescale 1ns/100ps
module spalu_io_model (
   input wire logic i_core_clk,
   output logic o_load_issue,
   output spalu_pkg::spalu_res_s o_result
);
   initial begin
      o_load_issue = 1'b0;
      o_result = '0;
   end
   task automatic load(input logic [7:0] idx, input int len, gap, input logic short_pool);
      @(posedge i_core_clk) o_load_issue <= 1'b1;
      @(posedge i_core_clk) o_load_issue <= 1'b0;
      repeat (gap) @(posedge i_core_clk);
      for (int k = 0; k < len; k++) begin
         o_result <= '{1'b1, idx + 8'(k), short_pool,
            64'h1234_5678_9abc_def0 ^ 64'(idx + 8'(k)), k == len - 1};
         @(posedge i_core_clk);
      end
      // Idle bus must not look like the last word
      o_result.valid <= 1'b0;
      o_result.data <= ~o_result.data;
   endtask
endmodule // spalu_io_model

// ### test/spalu_top_bench.sv
// Self-checking bench for the scratchpad and async load unit.
// Assumes the I/O model drives results; the checker is bound below.
`timescale 1ns/100ps
module spalu_top_bench;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ctl_wr = 1'b0;
   logic [63:0] i_ctl_wdata = '0;
   logic i_sync_instr = 1'b0;
   spalu_pkg::spalu_req_s i_req = '0;
   logic [63:0] o_ctl_rdata, o_rsp_rdata;
   logic [5:0] o_dcache_lines_taken;
   logic o_rsp_valid, o_addr_error, o_stall, ld_issue;
   spalu_pkg::spalu_res_s ld_res;
   logic [63:0] spm [256];
   logic [8:0] ctl_m = '0;
   int n_fail = 0, compares = 0, cyc = 0, seed = 32'h1870;
   always #20 i_core_clk = ~i_core_clk;
   spalu_top u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ctl_wr(i_ctl_wr),
      .i_ctl_wdata(i_ctl_wdata), .o_ctl_rdata(o_ctl_rdata),
      .o_dcache_lines_taken(o_dcache_lines_taken), .i_req(i_req), .o_rsp_valid(o_rsp_valid),
      .o_rsp_rdata(o_rsp_rdata), .o_addr_error(o_addr_error), .i_load_issue(ld_issue),
      .i_result(ld_res), .i_sync_instr(i_sync_instr), .o_stall(o_stall));
   spalu_io_model u_io (.i_core_clk(i_core_clk), .o_load_issue(ld_issue), .o_result(ld_res));
   task automatic chk(input logic [63:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic ctl(input logic [63:0] d);
      @(posedge i_core_clk) i_ctl_wr <= 1'b1;
      i_ctl_wdata <= d;
      ctl_m = d[8:0];
      @(posedge i_core_clk) i_ctl_wr <= 1'b0;
      #1 chk(o_ctl_rdata, {55'h0, ctl_m});
      chk(64'(o_dcache_lines_taken), 64'(d[5:0]));
   endtask
   task automatic acc(input logic wr, input int off, input logic [7:0] be,
      input logic [63:0] wd, input int m);
      logic err;
      logic [63:0] exp;
      @(posedge i_core_clk) i_req <= '{1'b1, wr, spalu_pkg::SCRATCH_VIRTUAL_BASE + 64'(off),
         be, wd, spalu_pkg::spalu_mode_e'(m)};
      err = !ctl_m[6 + m] || off >= int'(ctl_m[5:0]) * 128;
      exp = (err || wr) ? '0 : spm[off / 8];
      for (int b = 0; b < 8; b++)
         if (!err && wr && be[b]) spm[off / 8][8 * b +: 8] = wd[8 * b +: 8];
      @(posedge i_core_clk) i_req.valid <= 1'b0;
      #1 chk(64'({o_rsp_valid, o_addr_error}), 64'({1'b1, err}));
      chk(o_rsp_rdata, exp);
   endtask
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_sim;
      end
   end
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_rst <= 1'b0;
      #1 chk(o_ctl_rdata | 64'(o_stall), '0);
      ctl(64'hffff_ffff_ffff_fe04);
      for (int e = 0; e < 8; e++) begin
         ctl(64'(e << 6) | 64'h4);
         for (int m = 0; m < 3; m++) acc(1, 8 * m, 8'hff, 64'(e), m);
      end
      // slots preset with random markers before the loads
      for (int w = 0; w < 64; w++) acc(1, 8 * w, 8'hff, {$random(seed), $random(seed)}, 2);
      repeat (40) acc(1'($random(seed)), $random(seed) & 32'h3ff, 8'($random(seed)),
         {$random(seed), $random(seed)}, 2);
      // no cache model, so invalidation after resize is implied
      ctl(64'h1c0);
      acc(0, 0, 8'hff, 0, 2);
      ctl(64'h104);
      @(posedge i_core_clk) i_sync_instr <= 1'b1;
      #1 chk(64'(o_stall), 0);
      @(posedge i_core_clk) i_sync_instr <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         fork
            u_io.load(8'(5 + 20 * s), 3 + s, 4, s[0]);
            begin
               repeat (2) @(posedge i_core_clk);
               i_sync_instr <= 1'b1;
               #1 chk(64'(o_stall), 1);
               @(posedge i_core_clk) i_sync_instr <= 1'b0;
            end
         join
         #1 chk(64'(o_stall), 0);
         for (int k = 0; k < 3 + s; k++)
            spm[5 + 20 * s + k] = s ? '0 : 64'h1234_5678_9abc_def0 ^ 64'(5 + k);
         for (int k = -1; k <= 3 + s; k++) acc(0, 8 * (5 + 20 * s + k), 0, 0, 2);
      end
      end_sim;
   end
endmodule // spalu_top_bench
bind spalu_top spalu_properties u_prop (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata), .o_ctl_rdata(o_ctl_rdata), .i_req(i_req),
   .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .o_addr_error(o_addr_error),
   .i_result(i_result), .o_stall(o_stall));
